// *** ifl_defines.svh ***
/*
 * constants for the two-wire bus flag logic: event indices and bit counts.
 * assumes inclusion by every design file of the block, definitions only.
 */
`ifndef IFL_DEFINES_SVH
`define IFL_DEFINES_SVH

`define IFL_EV_START     0
`define IFL_EV_STOP      1
`define IFL_EV_CLK8_RISE 2
`define IFL_EV_CLK8_FALL 3
`define IFL_EV_CLK9_RISE 4
`define IFL_EV_ARB_LOST  5
`define IFL_EV_NUM       6
`define IFL_DATA_W       8
`define IFL_DATA_BITS    4'h8
`define IFL_SYNC_LAST    4'h8
`define IFL_I2C_LAST     4'h9
`define IFL_BYTE_RST     8'h00

`endif

// *** ifl_pkg.sv ***
/*
 * types shared by the two-wire bus flag logic and its link engine.
 * assumes ifl_defines.svh is visible on the include path.
 */
`include "ifl_defines.svh"

package ifl_pkg;

   typedef struct packed {
      logic arb_lost;
      logic clk9_rise;
      logic clk8_fall;
      logic clk8_rise;
      logic stop;
      logic start;
   } ifl_event_t;

   typedef struct packed {
      logic                   wr;
      logic                   rd;
      logic                   by_xfer_ctrl;
      logic                   xfer_last;
      logic [`IFL_DATA_W-1:0] wdata;
   } ifl_data_req_t;

   typedef struct packed {
      logic wr;
      logic master;
      logic transmit;
   } ifl_ctrl_wr_t;

   typedef struct packed {
      logic sync_format;
      logic wait_enable;
      logic ack_check_enable;
   } ifl_mode_t;

   typedef struct packed {
      logic irq_request_flag;
      logic continuous_xfer_flag;
      logic tx_buffer_empty_flag;
      logic rx_buffer_full_flag;
      logic master_select_bit;
      logic transmit_select_bit;
      logic bus_busy_bit;
      logic arbitration_lost_flag;
      logic ack_received_bit;
   } ifl_flags_t;

endpackage

// *** ifl_evsync.sv ***
/*
 * toggle-to-pulse crossing for link events into the system clock.
 * assumes each source toggle changes at most once per few destination cycles.
 */
`timescale 1ns/100ps

module ifl_evsync #(
   parameter int W = 6
) (
   input  wire logic         dst_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] tgl_in,
   output logic      [W-1:0] pulse
);
   import ifl_pkg::*;

   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] sync;
      logic [W-1:0] last;
      logic [W-1:0] pulse;
   } ifl_evsync_t;

   ifl_evsync_t st_reg;
   ifl_evsync_t st_next;

   always_comb begin
      st_next       = st_reg;
      st_next.meta  = tgl_in;
      st_next.sync  = st_reg.meta;
      st_next.last  = st_reg.sync;
      st_next.pulse = st_reg.sync ^ st_reg.last;
   end

   always_ff @(posedge dst_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign pulse = st_reg.pulse;
endmodule

// *** ifl_link.sv ***
/*
 * link engine on the link clock: samples scl/sda, finds start, stop and
 * clock edges, shifts bytes, and reports events as toggles.
 * assumes link_clk runs free and oversamples scl by several cycles.
 */
`timescale 1ns/100ps
`include "ifl_defines.svh"

module ifl_link (
   input  wire logic                   link_clk,
   input  wire logic                   rst_b,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   input  wire logic                   sync_format,
   input  wire logic                   transmit,
   input  wire logic [`IFL_DATA_W-1:0] tx_byte,
   input  wire logic                   load_tgl,
   output logic      [`IFL_EV_NUM-1:0] ev_tgl,
   output logic      [`IFL_DATA_W-1:0] rx_byte,
   output logic                        ack_bit,
   output logic                        sda_out,
   output logic                        sda_oe_n
);
   import ifl_pkg::*;

   typedef struct packed {
      logic [2:0]             scl_p;
      logic [2:0]             sda_p;
      logic [1:0]             fmt_p;
      logic [1:0]             tx_p;
      logic [2:0]             ld_p;
      logic [3:0]             bitcnt;
      logic [`IFL_DATA_W-1:0] shifter;
      logic [`IFL_DATA_W-1:0] rx_byte;
      logic                   ack;
      logic [`IFL_EV_NUM-1:0] ev_tgl;
      logic                   drive;
      logic                   sda_out;
      logic                   sda_oe_n;
   } ifl_link_t;

   ifl_link_t  st_reg;
   ifl_link_t  st_next;
   logic       rise;
   logic       fall;
   logic       start;
   logic       stop;
   logic [3:0] last;

   always_comb begin
      st_next       = st_reg;
      st_next.scl_p = {st_reg.scl_p[1:0], scl_in};
      st_next.sda_p = {st_reg.sda_p[1:0], sda_in};
      st_next.fmt_p = {st_reg.fmt_p[0], sync_format};
      st_next.tx_p  = {st_reg.tx_p[0], transmit};
      st_next.ld_p  = {st_reg.ld_p[1:0], load_tgl};
      rise  = st_reg.scl_p[1] & ~st_reg.scl_p[2];
      fall  = ~st_reg.scl_p[1] & st_reg.scl_p[2];
      start = st_reg.scl_p[1] & st_reg.scl_p[2] & ~st_reg.sda_p[1] & st_reg.sda_p[2];
      stop  = st_reg.scl_p[1] & st_reg.scl_p[2] & st_reg.sda_p[1] & ~st_reg.sda_p[2];
      last  = st_reg.fmt_p[1] ? `IFL_SYNC_LAST : `IFL_I2C_LAST;
      if (st_reg.ld_p[2] ^ st_reg.ld_p[1]) begin
         st_next.shifter  = tx_byte;
         st_next.drive    = st_reg.tx_p[1];
         if (!st_reg.scl_p[1] && st_reg.bitcnt == 4'h0) begin
            st_next.sda_out  = tx_byte[7];
            st_next.sda_oe_n = ~(st_reg.tx_p[1] & ~tx_byte[7]);
         end
      end
      if (start) begin
         st_next.bitcnt = 4'h0;
         st_next.ev_tgl[`IFL_EV_START] = ~st_reg.ev_tgl[`IFL_EV_START];
      end else if (stop) begin
         st_next.bitcnt   = 4'h0;
         st_next.drive    = 1'b0;
         st_next.sda_out  = 1'b1;
         st_next.sda_oe_n = 1'b1;
         st_next.ev_tgl[`IFL_EV_STOP] = ~st_reg.ev_tgl[`IFL_EV_STOP];
      end else if (rise) begin
         st_next.bitcnt = st_reg.bitcnt + 4'h1;
         if (st_reg.bitcnt < `IFL_DATA_BITS) begin
            if (!st_reg.tx_p[1]) begin
               st_next.shifter = {st_reg.shifter[6:0], st_reg.sda_p[1]};
            end
            if (st_reg.drive && st_reg.sda_out && !st_reg.sda_p[1]) begin
               st_next.drive    = 1'b0;
               st_next.sda_oe_n = 1'b1;
               st_next.ev_tgl[`IFL_EV_ARB_LOST] = ~st_reg.ev_tgl[`IFL_EV_ARB_LOST];
            end
         end
         if (st_reg.bitcnt == `IFL_DATA_BITS - 4'h1) begin
            st_next.rx_byte = {st_reg.shifter[6:0], st_reg.sda_p[1]};
            st_next.ev_tgl[`IFL_EV_CLK8_RISE] = ~st_reg.ev_tgl[`IFL_EV_CLK8_RISE];
         end
         if (st_reg.bitcnt == `IFL_DATA_BITS) begin
            st_next.ack = st_reg.sda_p[1];
            st_next.ev_tgl[`IFL_EV_CLK9_RISE] = ~st_reg.ev_tgl[`IFL_EV_CLK9_RISE];
         end
         if (st_reg.bitcnt + 4'h1 == last) begin
            st_next.bitcnt = 4'h0;
         end
      end else if (fall) begin
         if (st_reg.bitcnt == `IFL_DATA_BITS) begin
            st_next.drive    = 1'b0;
            st_next.sda_out  = 1'b1;
            st_next.sda_oe_n = 1'b1;
         end else if (st_reg.bitcnt == 4'h0) begin
            st_next.sda_out  = ~st_next.drive | st_next.shifter[7];
            st_next.sda_oe_n = st_next.sda_out;
         end else if (st_reg.drive) begin
            st_next.shifter  = {st_reg.shifter[6:0], 1'b0};
            st_next.sda_out  = st_reg.shifter[6];
            st_next.sda_oe_n = st_reg.shifter[6];
         end
         if (st_reg.bitcnt == `IFL_DATA_BITS) begin
            st_next.ev_tgl[`IFL_EV_CLK8_FALL] = ~st_reg.ev_tgl[`IFL_EV_CLK8_FALL];
         end
      end
   end

   always_ff @(posedge link_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg          <= '0;
         st_reg.scl_p    <= 3'h7;
         st_reg.sda_p    <= 3'h7;
         st_reg.sda_out  <= 1'b1;
         st_reg.sda_oe_n <= 1'b1;
      end else begin
         st_reg <= st_next;
      end
   end

   assign ev_tgl   = st_reg.ev_tgl;
   assign rx_byte  = st_reg.rx_byte;
   assign ack_bit  = st_reg.ack;
   assign sda_out  = st_reg.sda_out;
   assign sda_oe_n = st_reg.sda_oe_n;
endmodule

// *** ifl_top.sv ***
/*
 * flag and interrupt-request logic of a two-wire bus interface, with the
 * buffer moves between holding buffers and the shift register.
 * assumes cpu and transfer controller strobes are one-cycle pulses on sys_clk,
 * scl/sda arrive from pins, and link_clk is a free-running sampling clock.
 */
`timescale 1ns/100ps
`include "ifl_defines.svh"

// How it works
// R1: clocked synchronous format raises the request flag at the 8th clock rise.
// R2: clocked synchronous format raises the request flag on a start condition.
// R3: start seen in transmit mode sets empty flag and request flag.
// R4: each buffer move raises the request flag plus empty or full flag.
// R5: request flag clears by writing 0 after reading 1; writing 1 does nothing.
// R6: transfer controller data access clears the request flag automatically.
// R7: software checks other flags to learn what raised the request flag.
// R8: continuous-transfer flag is not raised for every buffer event.
// R9: request and continuous flags may rise without empty or full flags.
// R10: after the last controller transfer, request and continuous flags stay set.
// R11: master idle has master and transmit at 1, bus-busy at 0.
// R12: master transmit byte end with empty at 0 sets empty and continuous flag.
// R13: master transmit data write clears the empty flag.
// R14: byte end with empty at 1 holds; next write moves and sets flags again.
// R15: master receive byte end with full at 0 sets full and continuous flag.
// R16: master receive data read while full clears the full flag.
// R17: byte end with full at 1 holds; after the read, the move sets flags again.
// R18: raising the continuous flag raises the request flag together with it.
// R19: with wait enabled, two-wire master raises request at 8th clock fall.
// R20: without wait, two-wire master raises request at 9th clock rise.
// R21: lost arbitration clears master and transmit, sets lost flag, keeps busy.
// R22: master start sets busy, empty, continuous; stop clears busy and empty.
module ifl_top (
   input  wire logic                   sys_clk,
   input  wire logic                   rst_b,
   input  wire logic                   link_clk,
   input  wire logic                   scl_in,
   input  wire logic                   sda_in,
   output logic                        sda_out,
   output logic                        sda_oe_n,
   input  wire ifl_pkg::ifl_mode_t     mode,
   input  wire ifl_pkg::ifl_ctrl_wr_t  ctrl,
   input  wire logic                   status_rd,
   input  wire logic                   status_wr,
   input  wire ifl_pkg::ifl_flags_t    status_wdata,
   input  wire ifl_pkg::ifl_data_req_t data_req,
   output logic      [`IFL_DATA_W-1:0] rx_data,
   output ifl_pkg::ifl_flags_t         flags
);
   import ifl_pkg::*;

   typedef struct packed {
      ifl_flags_t             flags;
      logic [`IFL_DATA_W-1:0] rx_hold;
      logic [`IFL_DATA_W-1:0] rx_shadow;
      logic [`IFL_DATA_W-1:0] tx_hold;
      logic [`IFL_DATA_W-1:0] tx_shift;
      logic                   load_tgl;
      logic                   tx_idle;
      logic                   tx_move;
      logic                   rx_pend;
      logic                   rx_move;
      logic                   irq_armed;
      logic                   cxfer_armed;
      logic                   al_armed;
   } ifl_top_state_t;

   ifl_top_state_t         st_reg;
   ifl_top_state_t         st_next;
   logic [`IFL_EV_NUM-1:0] ev_tgl;
   logic [`IFL_EV_NUM-1:0] ev_pulse;
   ifl_event_t             ev;
   logic [`IFL_DATA_W-1:0] link_rx_byte;
   logic                   link_ack;
   logic                   link_sda_out;
   logic                   link_sda_oe_n;
   logic                   byte_end;
   logic                   data_write;
   logic                   data_read;

   // request flag, plus continuous flag only while master
   function automatic ifl_flags_t raise_xfer(input ifl_flags_t f);
      ifl_flags_t r;
      r = f;
      // R8: no continuous flag outside master
      if (f.master_select_bit) begin
         r.continuous_xfer_flag = 1'b1;
      end
      // R18: request rises with it
      r.irq_request_flag = 1'b1;
      return r;
   endfunction

   ifl_link u_link (
      .link_clk    (link_clk),
      .rst_b       (rst_b),
      .scl_in      (scl_in),
      .sda_in      (sda_in),
      .sync_format (mode.sync_format),
      .transmit    (st_reg.flags.transmit_select_bit),
      .tx_byte     (st_reg.tx_shift),
      .load_tgl    (st_reg.load_tgl),
      .ev_tgl      (ev_tgl),
      .rx_byte     (link_rx_byte),
      .ack_bit     (link_ack),
      .sda_out     (link_sda_out),
      .sda_oe_n    (link_sda_oe_n)
   );

   ifl_evsync #(
      .W (`IFL_EV_NUM)
   ) u_evsync (
      .dst_clk (sys_clk),
      .rst_b   (rst_b),
      .tgl_in  (ev_tgl),
      .pulse   (ev_pulse)
   );

   assign ev = ifl_event_t'(ev_pulse);

   always_comb begin
      st_next    = st_reg;
      data_write = data_req.wr & st_reg.flags.transmit_select_bit;
      data_read  = data_req.rd & ~st_reg.flags.transmit_select_bit;
      // R1: synchronous format ends at 8th rise
      if (mode.sync_format) begin
         byte_end = ev.clk8_rise;
      // R19: wait option ends at 8th fall
      end else if (mode.wait_enable) begin
         byte_end = ev.clk8_fall;
      // R20: otherwise 9th rise
      end else begin
         byte_end = ev.clk9_rise;
      end

      // clears first so that any set below wins
      if (status_rd) begin
         st_next.irq_armed   = st_reg.flags.irq_request_flag;
         st_next.cxfer_armed = st_reg.flags.continuous_xfer_flag;
         st_next.al_armed    = st_reg.flags.arbitration_lost_flag;
      end
      // R5: zero after a read of one
      if (status_wr) begin
         if (!status_wdata.irq_request_flag && st_reg.irq_armed) begin
            st_next.flags.irq_request_flag = 1'b0;
            st_next.irq_armed              = 1'b0;
         end
         if (!status_wdata.continuous_xfer_flag && st_reg.cxfer_armed) begin
            st_next.flags.continuous_xfer_flag = 1'b0;
            st_next.cxfer_armed                = 1'b0;
         end
         if (!status_wdata.arbitration_lost_flag && st_reg.al_armed) begin
            st_next.flags.arbitration_lost_flag = 1'b0;
            st_next.al_armed                    = 1'b0;
         end
      end
      // R11: software sets master and transmit
      if (ctrl.wr) begin
         st_next.flags.master_select_bit   = ctrl.master;
         st_next.flags.transmit_select_bit = ctrl.transmit;
      end
      // R6: controller access clears request
      if ((data_req.wr || data_req.rd) && data_req.by_xfer_ctrl) begin
         // R10: last transfer leaves flags set
         if (!data_req.xfer_last) begin
            st_next.flags.irq_request_flag = 1'b0;
         end
      end
      // R13: data write empties nothing pending
      if (data_write) begin
         st_next.tx_hold                    = data_req.wdata;
         st_next.flags.tx_buffer_empty_flag = 1'b0;
      end
      // R16: read clears full flag
      if (data_read && st_reg.flags.rx_buffer_full_flag) begin
         st_next.flags.rx_buffer_full_flag = 1'b0;
      end

      // R14: delayed move after write
      if (st_reg.tx_move) begin
         st_next.tx_shift                   = st_reg.tx_hold;
         st_next.load_tgl                   = ~st_reg.load_tgl;
         st_next.tx_idle                    = 1'b0;
         // R4: move sets empty and request
         st_next.flags.tx_buffer_empty_flag = 1'b1;
         st_next.flags                      = raise_xfer(st_next.flags);
      end
      // R17: delayed move after read
      if (st_reg.rx_move) begin
         st_next.rx_hold                   = st_reg.rx_shadow;
         st_next.rx_pend                   = 1'b0;
         // R4: move sets full and request
         st_next.flags.rx_buffer_full_flag = 1'b1;
         st_next.flags                     = raise_xfer(st_next.flags);
      end

      if (ev.start) begin
         st_next.flags.bus_busy_bit = 1'b1;
         // R2: synchronous start requests
         if (mode.sync_format) begin
            // R9: request without buffer flags
            st_next.flags.irq_request_flag = 1'b1;
         end
         // R3: start in transmit empties buffer
         if (st_reg.flags.transmit_select_bit) begin
            st_next.flags.tx_buffer_empty_flag = 1'b1;
            st_next.flags.irq_request_flag     = 1'b1;
            st_next.tx_idle                    = 1'b1;
         end
         // R22: master start flags
         if (st_reg.flags.master_select_bit) begin
            st_next.flags.tx_buffer_empty_flag = 1'b1;
            st_next.flags                      = raise_xfer(st_next.flags);
         end
      end

      // R22: stop releases bus
      if (ev.stop) begin
         st_next.flags.bus_busy_bit         = 1'b0;
         st_next.flags.tx_buffer_empty_flag = 1'b0;
         st_next.tx_idle                    = 1'b0;
      end

      if (byte_end) begin
         // R1: byte end requests
         st_next.flags.irq_request_flag = 1'b1;
         if (st_reg.flags.transmit_select_bit) begin
            if (!st_reg.flags.tx_buffer_empty_flag && !st_reg.tx_move) begin
               // R12: move waiting byte now
               st_next.tx_shift                   = st_reg.tx_hold;
               st_next.load_tgl                   = ~st_reg.load_tgl;
               st_next.flags.tx_buffer_empty_flag = 1'b1;
               st_next.flags                      = raise_xfer(st_next.flags);
            end else begin
               // R14: hold until next write
               st_next.tx_idle = 1'b1;
            end
         end else begin
            if (!st_reg.flags.rx_buffer_full_flag) begin
               // R15: byte straight to holding
               st_next.rx_hold                   = link_rx_byte;
               st_next.flags.rx_buffer_full_flag = 1'b1;
               st_next.flags                     = raise_xfer(st_next.flags);
            end else begin
               // R17: park byte until read
               st_next.rx_shadow = link_rx_byte;
               st_next.rx_pend   = 1'b1;
            end
         end
      end

      if (ev.clk9_rise && !mode.sync_format) begin
         st_next.flags.ack_received_bit = link_ack;
         if (mode.ack_check_enable && link_ack) begin
            st_next.flags.irq_request_flag = 1'b1;
         end
      end

      // R21: arbitration lost
      if (ev.arb_lost) begin
         st_next.flags.master_select_bit     = 1'b0;
         st_next.flags.transmit_select_bit   = 1'b0;
         st_next.flags.arbitration_lost_flag = 1'b1;
      end

      // R14: schedule move once written
      st_next.tx_move = st_next.tx_idle & ~st_next.flags.tx_buffer_empty_flag
                        & st_next.flags.transmit_select_bit;
      // R17: schedule move once read
      st_next.rx_move = st_next.rx_pend & ~st_next.flags.rx_buffer_full_flag;
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign flags    = st_reg.flags;
   assign rx_data  = st_reg.rx_hold;
   assign sda_out  = link_sda_out;
   assign sda_oe_n = link_sda_oe_n;
endmodule

// *** ifl_top_checker.sv ***
/*
 * concurrent checks on the flag outputs of ifl_top.
 * assumes binding to ifl_top; sees only its ports.
 */
`timescale 1ns/100ps
`include "ifl_defines.svh"
module ifl_top_checker (
   input wire logic                   sys_clk,
   input wire logic                   rst_b,
   input wire logic                   link_clk,
   input wire logic                   scl_in,
   input wire logic                   sda_in,
   input wire logic                   sda_out,
   input wire logic                   sda_oe_n,
   input wire ifl_pkg::ifl_mode_t     mode,
   input wire ifl_pkg::ifl_ctrl_wr_t  ctrl,
   input wire logic                   status_rd,
   input wire logic                   status_wr,
   input wire ifl_pkg::ifl_flags_t    status_wdata,
   input wire ifl_pkg::ifl_data_req_t data_req,
   input wire logic [`IFL_DATA_W-1:0] rx_data,
   input wire ifl_pkg::ifl_flags_t    flags
);
   import ifl_pkg::*;
   wire logic irq = flags.irq_request_flag;
   wire logic cx  = flags.continuous_xfer_flag;
   wire logic em  = flags.tx_buffer_empty_flag;
   wire logic fu  = flags.rx_buffer_full_flag;
   wire logic ms  = flags.master_select_bit;
   wire logic tr  = flags.transmit_select_bit;
   wire logic bb  = flags.bus_busy_bit;
   wire logic dma = data_req.by_xfer_ctrl;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   property p_cx_irq; $rose(cx) |-> irq; endproperty
   a_cx_irq: assert property (p_cx_irq) else $error("continuous flag without request");
   property p_em_irq; $rose(em) |-> irq; endproperty
   a_em_irq: assert property (p_em_irq) else $error("empty flag without request");
   property p_fu_irq; $rose(fu) |-> irq; endproperty
   a_fu_irq: assert property (p_fu_irq) else $error("full flag without request");
   property p_wr_clr; data_req.wr && tr && em |=> !em; endproperty
   a_wr_clr: assert property (p_wr_clr) else $error("data write kept empty flag");
   property p_rd_clr; data_req.rd && !tr && fu |=> !fu; endproperty
   a_rd_clr: assert property (p_rd_clr) else $error("data read kept full flag");
   property p_one_ign; status_wr && status_wdata.irq_request_flag && irq && !dma |=> irq; endproperty
   a_one_ign: assert property (p_one_ign) else $error("writing one cleared request");
   property p_auto; data_req.rd && dma && !data_req.xfer_last && fu |=> !irq; endproperty
   a_auto: assert property (p_auto) else $error("controller read kept request");
   property p_last; data_req.rd && dma && data_req.xfer_last && irq && !status_wr |=> irq; endproperty
   a_last: assert property (p_last) else $error("last access cleared request");
   property p_stop; $fell(bb) |-> !em; endproperty
   a_stop: assert property (p_stop) else $error("stop left empty flag set");
   property p_arb; $rose(flags.arbitration_lost_flag) |-> !ms && !tr && bb; endproperty
   a_arb: assert property (p_arb) else $error("lost arbitration flags wrong");
endmodule

bind ifl_top ifl_top_checker i_chk (.sys_clk, .rst_b, .link_clk, .scl_in, .sda_in, .sda_out,
   .sda_oe_n, .mode, .ctrl, .status_rd, .status_wr, .status_wdata, .data_req, .rx_data, .flags);

// *** ifl_bus_model.sv ***
/*
 * far-side bus party: makes scl, start, stop and nine-clock bytes.
 * assumes sda has a pull-up; scl stands still between frames.
 */
`timescale 1ns/100ps
module ifl_bus_model #(
   parameter int Q = 320
) (
   input  wire logic sda_line,
   output logic      scl,
   output logic      sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic start_cond();
      sda_drv = 1'b0;
      #Q scl = 1'b0;
   endtask
   task automatic stop_cond();
      sda_drv = 1'b0;
      #Q scl = 1'b1;
      #Q sda_drv = 1'b1;
      #Q;
   endtask
   // msb first, ack on ninth clock
   task automatic xfer(input logic [7:0] tx, input logic ack, output logic [7:0] rx);
      logic [8:0] bits;
      bits = {tx, ack};
      for (int i = 8; i >= 0; i--) begin
         #Q sda_drv = bits[i];
         #Q scl = 1'b1;
         if (i > 0) rx[i-1] = sda_line;
         #Q scl = 1'b0;
      end
   endtask
endmodule

// *** ifl_top_test.sv ***
/*
 * self-checking bench for ifl_top with a bus model on the far side.
 * assumes the checker binds itself from its own file.
 */
`timescale 1ns/100ps
module ifl_top_test;
   import ifl_pkg::*;
   logic          sys_clk;
   logic          link_clk;
   logic          rst_b;
   logic          scl;
   logic          sda_drv;
   logic          sda_out;
   logic          sda_oe_n;
   logic          status_rd;
   logic          status_wr;
   ifl_flags_t    status_wdata;
   ifl_mode_t     mode;
   ifl_ctrl_wr_t  ctrl;
   ifl_data_req_t data_req;
   ifl_flags_t    flags;
   logic [7:0]    rx_data;
   logic [7:0]    seen;
   logic [7:0]    b0;
   logic [7:0]    b1;
   logic [31:0]   seed;
   int            fails;
   int            tests_run;
   wire logic     sda = sda_drv & (sda_oe_n | sda_out);

   always #5 sys_clk = ~sys_clk;
   always #32 link_clk = ~link_clk;

   ifl_top i_dut (.sys_clk, .rst_b, .link_clk, .scl_in(scl), .sda_in(sda), .sda_out,
      .sda_oe_n, .mode, .ctrl, .status_rd, .status_wr, .status_wdata, .data_req,
      .rx_data, .flags);
   ifl_bus_model i_bus (.sda_line(sda), .scl, .sda_drv);

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   function automatic logic [8:0] fl(input logic [6:0] v);
      return {v, 2'b00};
   endfunction
   task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
      tests_run++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic acc(input logic [2:0] c, input logic [11:0] r, input logic [1:0] s,
                      input logic [8:0] wd);
      @(posedge sys_clk);
      ctrl <= c;
      data_req <= r;
      {status_rd, status_wr} <= s;
      status_wdata <= wd;
      @(posedge sys_clk);
      ctrl <= '0;
      data_req <= '0;
      {status_rd, status_wr} <= 2'b00;
      #1;
   endtask
   task automatic clr();
      acc(0, 0, 2'b10, 0);
      acc(0, 0, 2'b01, 0);
   endtask
   task automatic settle();
      repeat (60) @(posedge sys_clk);
      #1;
   endtask
   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", tests_run, fails);
      if (fails == 0 && tests_run > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   initial begin
      #200000;
      fails++;
      finish_test();
   end

   initial begin
      {sys_clk, link_clk, rst_b, status_rd, status_wr} = '0;
      {mode, ctrl, data_req, status_wdata} = '0;
      {fails, tests_run} = '0;
      seed = xs(32'he981);
      b0 = seed[7:0];
      seed = xs(seed);
      b1 = seed[7:0];
      repeat (4) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      chk("reset flags", 0, flags);
      acc(3'b111, 0, 0, 0);
      chk("idle", fl(7'b0000110), flags);
      i_bus.start_cond();
      settle();
      chk("start", fl(7'b1110111), flags);
      acc(0, 0, 2'b01, 0);
      chk("clear unread", fl(7'b1110111), flags);
      acc(0, 0, 2'b10, 0);
      acc(0, 0, 2'b01, 9'h1ff);
      chk("write one", fl(7'b1110111), flags);
      clr();
      chk("cleared", fl(7'b0010111), flags);
      acc(0, {4'b1000, b0}, 0, 0);
      chk("write", fl(7'b0000111), flags);
      @(posedge sys_clk);
      #1;
      chk("move", fl(7'b1110111), flags);
      clr();
      fork
         i_bus.xfer(8'hff, 1'b0, seen);
         begin
            repeat (100) @(posedge sys_clk);
            acc(0, {4'b1000, b1}, 0, 0);
            chk("write mid byte", fl(7'b0000111), flags);
         end
      join
      settle();
      chk("wire byte 0", {1'b0, b0}, {1'b0, seen});
      chk("end empty 0", fl(7'b1110111), flags);
      clr();
      i_bus.xfer(8'hff, 1'b0, seen);
      settle();
      chk("wire byte 1", {1'b0, b1}, {1'b0, seen});
      chk("end empty 1", fl(7'b1010111), flags);
      $display("transmit test done");
      seed = xs(seed);
      b0 = seed[7:0];
      seed = xs(seed);
      b1 = seed[7:0];
      @(posedge sys_clk) mode <= 3'b010;
      acc(3'b110, 0, 0, 0);
      acc(0, {4'b1000, 8'h5a}, 0, 0);
      i_bus.xfer(b0, 1'b1, seen);
      settle();
      chk("rx first", {1'b0, b0}, {1'b0, rx_data});
      chk("full set", fl(7'b1111101) | 9'h1, flags);
      i_bus.xfer(b1, 1'b1, seen);
      settle();
      chk("rx parked", {1'b0, b0}, {1'b0, rx_data});
      chk("full held", fl(7'b1111101) | 9'h1, flags);
      acc(0, {4'b0110, 8'h00}, 0, 0);
      chk("auto clear", fl(7'b0110101) | 9'h1, flags);
      @(posedge sys_clk);
      #1;
      chk("parked move", fl(7'b1111101) | 9'h1, flags);
      chk("rx second", {1'b0, b1}, {1'b0, rx_data});
      acc(0, {4'b0111, 8'h00}, 0, 0);
      chk("last access", fl(7'b1110101) | 9'h1, flags);
      $display("receive test done");
      i_bus.stop_cond();
      settle();
      chk("stop", fl(7'b1100100) | 9'h1, flags);
      $display("stop test done");
      finish_test();
   end
endmodule
